/* File: rtl/ddb_ctl.sv */
// Purpose: Memory controller end: schedules commands, drives the link.
// Assumes: CK_HALF is at least 2 so read data can be synchronised.
// Notes: The link clock is divided from ref_clk and driven out.
// What this block does
// - Activate a row before reading or writing.
// - Column commands wait the activate delay.
// - Precharge before new row; space activates.
// - Activates to different banks spaced apart.
// - Read data starts after CAS latency.
// - Read strobe has preamble, then released after the data.
// - Reads may follow reads any cycle.
// - Burst terminate stops reads after CAS latency.
// - Read burst ends before any write.
// - Precharge after read, then wait precharge time.
// - Read auto precharge waits for active time.
// - Write strobe preamble, data on edges, postamble.
// - First write strobe edge about one clock later.
// - Data after a write burst is ignored.
// - Writes may follow writes any cycle.
// - Read after write waits write-to-read time.
// - Read truncating write drops later pairs.
// - Precharge after write waits write recovery.
// - Precharge truncating write drops later pairs.
// - Write auto precharge closes row after burst.
// - High mask skips the byte.
// - Address bit ten selects auto precharge.
// - Burst terminate only on plain reads.
module ddb_ctl import ddb_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  ddb_link_if.ctl lk,
  input wire logic req_valid,
  output logic req_ready,
  input wire ddb_op_e req_op,
  input wire logic req_ap,
  input wire logic [BAW-1:0] req_ba,
  input wire logic [AW-1:0] req_row,
  input wire logic [COLW-1:0] req_col,
  input wire logic [PAIRS*PW-1:0] req_wdata,
  input wire logic [PAIRS*2-1:0] req_wmask,
  output logic [PW-1:0] rd_data,
  output logic rd_valid
);
  logic [PHW-1:0] ph_ff;
  logic ck_ff, tick, acc;
  logic [3:0] cmd_n, cmd_ff;
  logic [BAW-1:0] ba_ff;
  logic [AW-1:0] addr_ff;
  logic [NB-1:0] open_ff;
  logic [AW-1:0] row_ff [NB];
  logic [CW-1:0] rcd_ff [NB];
  logic [CW-1:0] rc_ff [NB];
  logic [CW-1:0] ras_ff [NB];
  logic [CW-1:0] rp_ff [NB];
  logic [CW-1:0] wr_ff [NB];
  logic [CW-1:0] rrd_ff, wtr_ff, rdb_ff, wdp_ff;
  logic rnap_ff, post_ff;
  logic [PAIRS*PW-1:0] wbuf_ff;
  logic [PAIRS*2-1:0] wmsk_ff;
  logic [PW-1:0] dq_ff, rd_data_ff;
  logic [1:0] dm_ff, dqs_ff;
  logic dqoe_ff, dqsoe_ff, rd_valid_ff;
  logic [PW-1:0] dq_s1, dq_s2;
  logic [1:0] dqs_s1, dqs_s2;
  logic oe_s1, oe_s2;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == '0) ? v : v - 6'h01;
  endfunction

  function automatic logic [AW-1:0] col_addr(
    input logic [COLW-1:0] c, input logic a);
    logic [AW-1:0] r;
    r = '0;
    r[COLW-1:0] = c;
    r[AP_BIT] = a;
    return r;
  endfunction

  // ==========================================================
  // Link clock divider; commands launch one ref_clk cycle before rise.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_ff <= '0;
      ck_ff <= 1'b0;
    end else begin
      ph_ff <= (ph_ff == PH_LAST) ? '0 : ph_ff + 1'b1;
      if (ph_ff == PH_CKHI) begin
        ck_ff <= 1'b1;
      end else if (ph_ff == PH_LAST) begin
        ck_ff <= 1'b0;
      end
    end
  end

  assign tick = ph_ff == '0;

  // ==========================================================
  // Command choice for the pending request at this link cycle.
  // Opening and closing rows is done here, so a request may take
  // several cycles before it is accepted.
  always_comb begin
    cmd_n = CMD_NOP;
    acc = 1'b0;
    case (req_op)
      OP_PRE: begin
        if (!open_ff[req_ba]) begin
          acc = 1'b1;
        end else if (ras_ff[req_ba] == '0 && wr_ff[req_ba] == '0) begin
          cmd_n = CMD_PRE;
          acc = 1'b1;
        end
      end
      OP_BST: begin
        acc = 1'b1;
        if (rdb_ff != '0 && rnap_ff) begin
          cmd_n = CMD_BST;
        end
      end
      default: begin
        if (!open_ff[req_ba]) begin
          if (rc_ff[req_ba] == '0 && rp_ff[req_ba] == '0 &&
              rrd_ff == '0) begin
            cmd_n = CMD_ACT;
          end
        end else if (row_ff[req_ba] != req_row) begin
          if (ras_ff[req_ba] == '0 && wr_ff[req_ba] == '0) begin
            cmd_n = CMD_PRE;
          end
        end else if (rcd_ff[req_ba] == '0) begin
          if (req_op == OP_RD && wtr_ff == '0) begin
            cmd_n = CMD_RD;
            acc = 1'b1;
          end else if (req_op == OP_WR && rdb_ff == '0) begin
            cmd_n = CMD_WR;
            acc = 1'b1;
          end
        end
      end
    endcase
    if (!req_valid || !tick) begin
      cmd_n = CMD_NOP;
      acc = 1'b0;
    end
  end

  assign req_ready = acc;

  // ==========================================================
  // Bank state.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      open_ff <= '0;
      for (int i = 0; i < NB; i++) begin
        row_ff[i] <= '0;
      end
    end else if (tick) begin
      if (cmd_n == CMD_ACT) begin
        open_ff[req_ba] <= 1'b1;
        row_ff[req_ba] <= req_row;
      end else if (cmd_n == CMD_PRE ||
          ((cmd_n == CMD_RD || cmd_n == CMD_WR) && req_ap)) begin
        open_ff[req_ba] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Per-bank timers, counted in link cycles.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NB; i++) begin
        rcd_ff[i] <= '0;
        rc_ff[i] <= '0;
        ras_ff[i] <= '0;
        rp_ff[i] <= '0;
        wr_ff[i] <= '0;
      end
    end else if (tick) begin
      for (int i = 0; i < NB; i++) begin
        rcd_ff[i] <= dec(rcd_ff[i]);
        rc_ff[i] <= dec(rc_ff[i]);
        ras_ff[i] <= dec(ras_ff[i]);
        rp_ff[i] <= dec(rp_ff[i]);
        wr_ff[i] <= dec(wr_ff[i]);
        if (req_ba == BAW'(i)) begin
          if (cmd_n == CMD_ACT) begin
            rcd_ff[i] <= T_RCD_CK;
            rc_ff[i] <= T_RC_CK;
            ras_ff[i] <= T_RAS_CK;
          end
          if (cmd_n == CMD_PRE) begin
            rp_ff[i] <= T_RP_CK;
          end
          if (cmd_n == CMD_WR) begin
            wr_ff[i] <= NPAIR + T_WR_CK;
            if (req_ap) begin
              rp_ff[i] <= NPAIR + T_WR_CK + T_RP_CK;
            end
          end
          if (cmd_n == CMD_RD && req_ap) begin
            rp_ff[i] <= ((ras_ff[i] > NCL + NPAIR) ? ras_ff[i] :
              NCL + NPAIR) + T_RP_CK;
          end
        end
      end
    end
  end

  // ==========================================================
  // Timers shared by all banks and the read bus.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rrd_ff <= '0;
      wtr_ff <= '0;
      rdb_ff <= '0;
      rnap_ff <= 1'b0;
    end else if (tick) begin
      rrd_ff <= (cmd_n == CMD_ACT) ? T_RRD_CK : dec(rrd_ff);
      wtr_ff <= (cmd_n == CMD_WR) ? NPAIR + T_WTR_CK : dec(wtr_ff);
      if (cmd_n == CMD_RD) begin
        rdb_ff <= NCL + NPAIR;
        rnap_ff <= !req_ap;
      end else if (cmd_n == CMD_BST) begin
        rdb_ff <= NCL;
      end else begin
        rdb_ff <= dec(rdb_ff);
      end
    end
  end

  // ==========================================================
  // Command and address pins.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_ff <= CMD_NOP;
      ba_ff <= '0;
      addr_ff <= '0;
    end else if (tick) begin
      cmd_ff <= cmd_n;
      ba_ff <= req_ba;
      addr_ff <= (cmd_n == CMD_ACT) ? req_row :
        col_addr(req_col, req_ap);
    end
  end

  // ==========================================================
  // Write data: preamble with the command, one pair per cycle,
  // then a postamble. Idle cycles keep the mask high so stray
  // pairs can never land in the array.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdp_ff <= '0;
      post_ff <= 1'b0;
      wbuf_ff <= '0;
      wmsk_ff <= '0;
      dq_ff <= '0;
      dm_ff <= DM_ALL;
      dqs_ff <= DQS_IDLE;
      dqoe_ff <= 1'b0;
      dqsoe_ff <= 1'b0;
    end else if (tick) begin
      if (wdp_ff != '0) begin
        dq_ff <= wbuf_ff[PW-1:0];
        dm_ff <= wmsk_ff[1:0];
        dqs_ff <= DQS_DATA;
        dqoe_ff <= 1'b1;
        dqsoe_ff <= 1'b1;
      end else begin
        dm_ff <= DM_ALL;
        dqs_ff <= DQS_IDLE;
        dqoe_ff <= 1'b0;
        dqsoe_ff <= cmd_n == CMD_WR || post_ff;
      end
      if (cmd_n == CMD_WR) begin
        wbuf_ff <= req_wdata;
        wmsk_ff <= req_wmask;
        wdp_ff <= NPAIR;
      end else if (wdp_ff != '0) begin
        wbuf_ff <= wbuf_ff >> PW;
        wmsk_ff <= wmsk_ff >> 2;
        wdp_ff <= wdp_ff - 6'h01;
      end
      post_ff <= wdp_ff == 6'h01 && cmd_n != CMD_WR;
    end
  end

  assign lk.ck = ck_ff;
  assign lk.cmd = cmd_ff;
  assign lk.ba = ba_ff;
  assign lk.addr = addr_ff;
  assign lk.dm = dm_ff;
  assign lk.ctl_dq_o = dq_ff;
  assign lk.ctl_dq_oe = dqoe_ff;
  assign lk.ctl_dqs_o = dqs_ff;
  assign lk.ctl_dqs_oe = dqsoe_ff;

  // ==========================================================
  // Read capture: the device launches on the link clock, so its
  // pins pass two flops; the capture point is the next launch
  // tick, by which the synchronised pair has settled.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      dqs_s1 <= DQS_IDLE;
      dqs_s2 <= DQS_IDLE;
      oe_s1 <= 1'b0;
      oe_s2 <= 1'b0;
    end else begin
      dq_s1 <= lk.dq;
      dq_s2 <= dq_s1;
      dqs_s1 <= lk.dqs;
      dqs_s2 <= dqs_s1;
      oe_s1 <= lk.dev_dqs_oe;
      oe_s2 <= oe_s1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= tick && oe_s2 && dqs_s2 == DQS_DATA;
      if (tick && oe_s2 && dqs_s2 == DQS_DATA) begin
        rd_data_ff <= dq_s2;
      end
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
endmodule // ddb_ctl

/* File: rtl/ddb_dev.sv */
// Purpose: Memory device end: banks, read and write bursts.
// Assumes: Clocked only by the link clock; one data pair per cycle.
// Notes: Only the low RSEL row bits and CSEL pair bits are stored.
module ddb_dev import ddb_pkg::*; #(
  parameter int RSEL = 2,
  parameter int CSEL = 4
) (
  input wire logic rst,
  ddb_link_if.dev lk,
  output logic [NB-1:0] bank_open,
  output logic rd_busy,
  output logic wr_busy
);
  localparam int MW = BAW + RSEL + CSEL;

  logic [PW-1:0] mem [2**MW];
  logic [NB-1:0] open_ff, apr_ff, apk_ff, bbusy;
  logic [RSEL-1:0] row_ff [NB];
  logic [CW-1:0] ras_ff [NB];
  logic [CL-1:0] pv_ff, ps_ff;
  logic [MW-1:0] pa_ff [CL];
  logic [BAW-1:0] pb_ff [CL];
  logic [CW-1:0] rdl_ff, wrl_ff;
  logic [MW-1:0] rda_ff, wra_ff;
  logic [BAW-1:0] rdb_ff, wrb_ff, lrb_ff;
  logic [PW-1:0] rdq_ff;
  logic is_act, is_rd, is_wr, is_pre, is_bst, ap, stop_rd, trunc_wr;
  logic [MW-1:0] cad;

  function automatic logic [MW-1:0] nxt_pair(input logic [MW-1:0] a);
    return {a[MW-1:PB], a[PB-1:0] + 1'b1};
  endfunction

  assign is_act = lk.cmd == CMD_ACT;
  assign is_rd = lk.cmd == CMD_RD;
  assign is_wr = lk.cmd == CMD_WR;
  assign is_pre = lk.cmd == CMD_PRE;
  assign is_bst = lk.cmd == CMD_BST;
  assign ap = lk.addr[AP_BIT];
  assign cad = {lk.ba, row_ff[lk.ba], lk.addr[CSEL:1]};
  assign stop_rd = is_bst || (is_pre && (ap || lk.ba == lrb_ff));
  assign trunc_wr = is_rd || (is_pre && (ap || lk.ba == wrb_ff));

  // ==========================================================
  // Read path: command pipeline of CL stages, then the burst.
  always_ff @(posedge lk.ck or posedge rst) begin
    if (rst) begin
      pv_ff <= '0;
      ps_ff <= '0;
      lrb_ff <= '0;
      for (int i = 0; i < CL; i++) begin
        pa_ff[i] <= '0;
        pb_ff[i] <= '0;
      end
    end else begin
      pv_ff[0] <= is_rd;
      ps_ff[0] <= stop_rd;
      pa_ff[0] <= cad;
      pb_ff[0] <= lk.ba;
      for (int i = 1; i < CL; i++) begin
        pv_ff[i] <= pv_ff[i-1];
        ps_ff[i] <= ps_ff[i-1];
        pa_ff[i] <= pa_ff[i-1];
        pb_ff[i] <= pb_ff[i-1];
      end
      if (is_rd) begin
        lrb_ff <= lk.ba;
      end
    end
  end

  // A new read wins over a stop arriving in the same cycle.
  always_ff @(posedge lk.ck or posedge rst) begin
    if (rst) begin
      rdl_ff <= '0;
      rda_ff <= '0;
      rdb_ff <= '0;
      rdq_ff <= '0;
    end else if (pv_ff[CL-1]) begin
      rdq_ff <= mem[pa_ff[CL-1]];
      rda_ff <= nxt_pair(pa_ff[CL-1]);
      rdb_ff <= pb_ff[CL-1];
      rdl_ff <= NPAIR;
    end else if (ps_ff[CL-1]) begin
      rdl_ff <= '0;
    end else if (rdl_ff > 6'h01) begin
      rdq_ff <= mem[rda_ff];
      rda_ff <= nxt_pair(rda_ff);
      rdl_ff <= rdl_ff - 6'h01;
    end else begin
      rdl_ff <= '0;
    end
  end

  // Preamble low one cycle ahead of data; pins released after.
  assign lk.dev_dq_o = rdq_ff;
  assign lk.dev_dq_oe = rdl_ff != '0;
  assign lk.dev_dqs_oe = rdl_ff != '0 || pv_ff[CL-1];
  assign lk.dev_dqs_o = (rdl_ff != '0) ? DQS_DATA : DQS_IDLE;

  // ==========================================================
  // Write path: pairs follow the command, one per cycle.
  always_ff @(posedge lk.ck or posedge rst) begin
    if (rst) begin
      wrl_ff <= '0;
      wra_ff <= '0;
      wrb_ff <= '0;
    end else if (is_wr) begin
      wrl_ff <= NPAIR;
      wra_ff <= cad;
      wrb_ff <= lk.ba;
    end else if (trunc_wr) begin
      wrl_ff <= '0;
    end else if (wrl_ff != '0) begin
      wra_ff <= nxt_pair(wra_ff);
      wrl_ff <= wrl_ff - 6'h01;
    end
  end

  // Only strobed pairs inside a live burst reach the array.
  always_ff @(posedge lk.ck) begin
    if (wrl_ff != '0 && !trunc_wr && lk.dqs == DQS_DATA) begin
      if (!lk.dm[0]) begin
        mem[wra_ff][DQW-1:0] <= lk.dq[DQW-1:0];
      end
      if (!lk.dm[1]) begin
        mem[wra_ff][PW-1:DQW] <= lk.dq[PW-1:DQW];
      end
    end
  end

  // ==========================================================
  // Banks and auto precharge.
  always_comb begin
    bbusy = '0;
    for (int b = 0; b < NB; b++) begin
      if ((rdl_ff != '0 && rdb_ff == BAW'(b)) ||
          (wrl_ff != '0 && wrb_ff == BAW'(b)) ||
          ((is_rd || is_wr) && lk.ba == BAW'(b))) begin
        bbusy[b] = 1'b1;
      end
      for (int i = 0; i < CL; i++) begin
        if (pv_ff[i] && pb_ff[i] == BAW'(b)) begin
          bbusy[b] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge lk.ck or posedge rst) begin
    if (rst) begin
      open_ff <= '0;
      apr_ff <= '0;
      apk_ff <= '0;
      for (int b = 0; b < NB; b++) begin
        row_ff[b] <= '0;
        ras_ff[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (ras_ff[b] != '0) begin
          ras_ff[b] <= ras_ff[b] - 6'h01;
        end
        if (apr_ff[b] && !bbusy[b] &&
            (ras_ff[b] == '0 || !apk_ff[b])) begin
          open_ff[b] <= 1'b0;
          apr_ff[b] <= 1'b0;
        end
        if (lk.ba == BAW'(b)) begin
          if (is_act) begin
            open_ff[b] <= 1'b1;
            row_ff[b] <= lk.addr[RSEL-1:0];
            ras_ff[b] <= T_RAS_CK;
          end
          if ((is_rd || is_wr) && ap) begin
            apr_ff[b] <= 1'b1;
            apk_ff[b] <= is_rd;
          end
        end
        if (is_pre && (ap || lk.ba == BAW'(b))) begin
          open_ff[b] <= 1'b0;
          apr_ff[b] <= 1'b0;
        end
      end
    end
  end

  assign bank_open = open_ff;
  assign rd_busy = rdl_ff != '0;
  assign wr_busy = wrl_ff != '0;
endmodule // ddb_dev

/* File: shared/ddb_link_if.sv */
// Purpose: Link between the memory controller and the memory device.
// Assumes: One data pair (two elements) per link clock cycle.
// Notes: Shared data pins are resolved here from the output enables.
interface ddb_link_if import ddb_pkg::*; ();
  logic ck;
  logic [3:0] cmd;
  logic [BAW-1:0] ba;
  logic [AW-1:0] addr;
  logic [1:0] dm;
  logic [PW-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [1:0] ctl_dqs_o;
  logic ctl_dqs_oe;
  logic [PW-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [1:0] dev_dqs_o;
  logic dev_dqs_oe;
  logic [PW-1:0] dq;
  logic [1:0] dqs;

  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : '0);

  modport ctl (output ck, cmd, ba, addr, dm, ctl_dq_o, ctl_dq_oe,
    ctl_dqs_o, ctl_dqs_oe, input dq, dqs, dev_dqs_oe);
  modport dev (input ck, cmd, ba, addr, dm, dq, dqs,
    output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe);
endinterface

/* File: shared/ddb_pkg.sv */
// Purpose: Shared constants and types for the DDR bank/burst link.
// Assumes: Link clock made by the controller end from ref_clk.
// Notes: Timing figures are plain defaults, converted to link cycles.
package ddb_pkg;
  // ==========================================================
  // Clocking
  localparam int REF_NS = 5;
  localparam int CK_HALF = 2;
  localparam int TCK_NS = 2 * CK_HALF * REF_NS;
  localparam int PHW = $clog2(2 * CK_HALF);
  localparam logic [PHW-1:0] PH_CKHI = PHW'(CK_HALF - 1);
  localparam logic [PHW-1:0] PH_LAST = PHW'(2 * CK_HALF - 1);
  // ==========================================================
  // Geometry
  localparam int DQW = 8;
  localparam int PW = 2 * DQW;
  localparam int BAW = 2;
  localparam int NB = 4;
  localparam int AW = 13;
  localparam int COLW = 10;
  localparam int AP_BIT = 10;
  localparam int CL = 2;
  localparam int BL = 4;
  localparam int PAIRS = BL / 2;
  localparam int PB = $clog2(PAIRS);
  localparam int CW = 6;
  // ==========================================================
  // Timing, least times rounded up to whole link cycles
  function automatic int ns2ck(input int ns);
    int c;
    c = (ns + TCK_NS - 1) / TCK_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int T_RCD_NS = 15;
  localparam int T_RC_NS = 60;
  localparam int T_RRD_NS = 10;
  localparam int T_RAS_NS = 40;
  localparam int T_RP_NS = 15;
  localparam int T_WTR_NS = 10;
  localparam int T_WR_NS = 15;
  localparam logic [CW-1:0] T_RCD_CK = CW'(ns2ck(T_RCD_NS));
  localparam logic [CW-1:0] T_RC_CK = CW'(ns2ck(T_RC_NS));
  localparam logic [CW-1:0] T_RRD_CK = CW'(ns2ck(T_RRD_NS));
  localparam logic [CW-1:0] T_RAS_CK = CW'(ns2ck(T_RAS_NS));
  localparam logic [CW-1:0] T_RP_CK = CW'(ns2ck(T_RP_NS));
  localparam logic [CW-1:0] T_WTR_CK = CW'(ns2ck(T_WTR_NS));
  localparam logic [CW-1:0] T_WR_CK = CW'(ns2ck(T_WR_NS));
  localparam logic [CW-1:0] NPAIR = CW'(PAIRS);
  localparam logic [CW-1:0] NCL = CW'(CL);
  // ==========================================================
  // Command bus {select_n, row_n, col_n, write_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  // Strobe per link cycle as {second half, first half}.
  localparam logic [1:0] DQS_IDLE = 2'h0;
  localparam logic [1:0] DQS_DATA = 2'h1;
  localparam logic [1:0] DM_ALL = 2'h3;
  typedef enum logic [1:0] {OP_RD, OP_WR, OP_PRE, OP_BST} ddb_op_e;
endpackage

/* File: sim/ddb_bank_burst_timing_tb.sv */
// Purpose: Drives requests into the controller and checks read data.
// Assumes: Controller and device face each other over one link.
// Notes: Expected data is worked out here from writes and masks.
module ddb_bank_burst_timing_tb import ddb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rst, req_valid, req_ready, req_ap, rd_valid;
  logic rd_busy, wr_busy;
  ddb_op_e req_op;
  logic [BAW-1:0] req_ba;
  logic [AW-1:0] req_row;
  logic [COLW-1:0] req_col;
  logic [31:0] req_wdata;
  logic [3:0] req_wmask, bank_open;
  logic [PW-1:0] rd_data;
  logic [PW-1:0] rq[$];
  int n_fail = 0;
  int n_checks = 0;
  ddb_link_if u_ddb_link_if ();
  ddb_ctl u_ddb_ctl (.ref_clk(ref_clk), .rst(rst), .lk(u_ddb_link_if.ctl),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_ap(req_ap), .req_ba(req_ba), .req_row(req_row),
    .req_col(req_col), .req_wdata(req_wdata), .req_wmask(req_wmask),
    .rd_data(rd_data), .rd_valid(rd_valid));
  ddb_dev u_ddb_dev (.rst(rst), .lk(u_ddb_link_if.dev),
    .bank_open(bank_open), .rd_busy(rd_busy), .wr_busy(wr_busy));
  ddb_link_properties u_ddb_link_properties (.ck(u_ddb_link_if.ck),
    .rst(rst), .cmd(u_ddb_link_if.cmd), .ba(u_ddb_link_if.ba),
    .dm(u_ddb_link_if.dm), .ctl_dq_oe(u_ddb_link_if.ctl_dq_oe),
    .ctl_dqs_oe(u_ddb_link_if.ctl_dqs_oe),
    .dev_dq_oe(u_ddb_link_if.dev_dq_oe),
    .dev_dqs_oe(u_ddb_link_if.dev_dqs_oe), .dqs(u_ddb_link_if.dqs));
  // ==========================================================
  // Clock, read capture and verdict
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Read data is taken mid-cycle, clear of the edge that updates it.
  always @(negedge ref_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // Request and read tasks
  task automatic req(input ddb_op_e op, input logic ap, input logic [1:0] b,
      input logic [12:0] row, input logic [9:0] col,
      input logic [31:0] wd, input logic [3:0] wm);
    logic hit;
    int n;
    hit = 1'b0;
    n = 0;
    @(posedge ref_clk);
    #1;
    req_op = op;
    {req_ap, req_ba, req_row, req_col} = {ap, b, row, col};
    {req_wdata, req_wmask, req_valid} = {wd, wm, 1'b1};
    while (!hit && n < 200) begin
      @(negedge ref_clk);
      hit = (req_ready === 1'b1);
      @(posedge ref_clk);
      n++;
    end
    #1 req_valid = 1'b0;
    if (!hit) chk(32'h0, 32'h1);
  endtask
  task automatic rd_chk(input logic ap, input logic [1:0] b,
      input logic [12:0] row, input logic [9:0] col, input logic [31:0] exp,
      input int np, input logic fol, input ddb_op_e fop);
    rq.delete();
    req(OP_RD, ap, b, row, col, '0, '0);
    if (fol) req(fop, 1'b0, b, row, col, '0, '0);
    repeat (80) @(posedge ref_clk);
    chk(32'(rq.size()), 32'(np));
    for (int i = 0; i < np && i < rq.size(); i++) begin
      chk(rq[i], exp[i*16+:16]);
    end
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    {req_valid, req_ap, req_ba, req_row} = '0;
    {req_col, req_wdata, req_wmask} = '0;
    req_op = OP_RD;
    rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    req(OP_WR, 0, 0, 5, 10'h010, 32'hB2B1A2A1, 4'h0);
    rd_chk(0, 0, 5, 10'h010, 32'hB2B1A2A1, 2, 0, OP_RD);
    req(OP_WR, 0, 0, 5, 10'h010, 32'h44332211, 4'h6);
    rd_chk(0, 0, 5, 10'h010, 32'h44B1A211, 2, 0, OP_RD);
    rd_chk(0, 0, 5, 10'h012, 32'hA21144B1, 2, 0, OP_RD);
    req(OP_WR, 0, 0, 6, 10'h010, 32'hCAFE0F0F, 4'h0);
    rd_chk(0, 0, 5, 10'h010, 32'h44B1A211, 2, 0, OP_RD);
    rd_chk(0, 0, 6, 10'h010, 32'hCAFE0F0F, 2, 0, OP_RD);
    req(OP_WR, 0, 1, 5, 10'h020, 32'h5A5A3C3C, 4'h0);
    rq.delete();
    req(OP_RD, 0, 0, 6, 10'h010, '0, '0);
    req(OP_RD, 0, 1, 5, 10'h020, '0, '0);
    repeat (80) @(posedge ref_clk);
    // The second read one cycle later cuts the first to a single pair.
    chk(32'(rq.size()), 32'd3);
    chk(32'(rq[0]), 32'h0F0F);
    chk({rq[2], rq[1]}, 32'h5A5A3C3C);
    chk(32'(bank_open[1]), 32'h1);
    rd_chk(0, 1, 5, 10'h020, 32'h5A5A3C3C, 1, 1, OP_BST);
    rd_chk(0, 0, 6, 10'h010, 32'hCAFE0F0F, 1, 1, OP_PRE);
    chk(32'(bank_open[0]), 32'h0);
    req(OP_WR, 1, 2, 3, 10'h008, 32'h96871E2D, 4'h0);
    repeat (40) @(posedge ref_clk);
    chk(32'(bank_open[2]), 32'h0);
    chk(32'(wr_busy), 32'h0);
    rd_chk(1, 2, 3, 10'h008, 32'h96871E2D, 2, 0, OP_RD);
    chk(32'(bank_open[2]), 32'h0);
    chk(32'(rd_busy), 32'h0);
    conclude();
  end
  initial begin
    #40000;
    n_fail++;
    conclude();
  end
endmodule // ddb_bank_burst_timing_tb

/* File: sim/ddb_link_properties.sv */
// Purpose: Link protocol checks between the controller and device ends.
// Assumes: The device end samples the link on the rising edge of ck; the controller end on ref_clk.
// Notes: Read latency is two link cycles, one data pair per cycle.
module ddb_link_properties import ddb_pkg::*; (
  input wire logic ck,
  input wire logic rst,
  input wire logic [3:0] cmd,
  input wire logic [BAW-1:0] ba,
  input wire logic [1:0] dm,
  input wire logic ctl_dq_oe,
  input wire logic ctl_dqs_oe,
  input wire logic dev_dq_oe,
  input wire logic dev_dqs_oe,
  input wire logic [1:0] dqs
);
  default clocking cb @(posedge ck); endclocking
  default disable iff (rst);
  // ==========================================================
  // Activate history
  logic [3:0] act_age_ff;
  logic [BAW-1:0] act_ba_ff;
  // The age saturates so a long idle stretch never wraps to a small value.
  always_ff @(posedge ck or posedge rst) begin
    if (rst) act_age_ff <= 4'hF;
    else if (cmd == CMD_ACT) act_age_ff <= 4'h1;
    else if (act_age_ff != 4'hF) act_age_ff <= act_age_ff + 4'h1;
  end
  always_ff @(posedge ck or posedge rst) begin
    if (rst) act_ba_ff <= '0;
    else if (cmd == CMD_ACT) act_ba_ff <= ba;
  end
  // ==========================================================
  // Properties
  // A read one cycle earlier is not yet visible on the strobe enable.
  chk_rd_first_pair: assert property (
    cmd == CMD_RD && !dev_dqs_oe && $past(cmd) != CMD_RD |->
      ##2 (dev_dqs_oe && !dev_dq_oe) ##1 dev_dq_oe)
    else $error("read data off latency");
  chk_rd_strobe: assert property (
    dev_dq_oe |-> dev_dqs_oe && dqs == DQS_DATA)
    else $error("read strobe missing");
  chk_bus_data: assert property (
    !(dev_dq_oe && ctl_dq_oe)) else $error("data bus fight");
  chk_bus_strobe: assert property (
    !(dev_dqs_oe && ctl_dqs_oe)) else $error("strobe bus fight");
  chk_wr_preamble: assert property (
    cmd == CMD_WR && !$past(ctl_dqs_oe) |->
      (ctl_dqs_oe && dqs == DQS_IDLE && !ctl_dq_oe)
      ##1 (ctl_dq_oe && dqs == DQS_DATA) [*2])
    else $error("write preamble or data wrong");
  chk_wr_postamble: assert property (
    $past(ctl_dq_oe) && !ctl_dq_oe |-> (ctl_dqs_oe && dqs == DQS_IDLE)
      ##1 (!ctl_dqs_oe || ctl_dq_oe || cmd == CMD_WR))
    else $error("write postamble wrong");
  chk_dm_idle: assert property (
    !ctl_dq_oe |-> dm == DM_ALL) else $error("mask open while idle");
  chk_bst_cut: assert property (
    cmd == CMD_BST ##1 cmd != CMD_RD |-> ##2 !dev_dq_oe)
    else $error("burst stop latency wrong");
  chk_act_spacing: assert property (
    cmd == CMD_ACT |->
      act_age_ff >= ((ba == act_ba_ff) ? T_RC_CK : T_RRD_CK))
    else $error("activates too close");
  cover property (cmd == CMD_BST);
  cover property (cmd == CMD_PRE);
  cover property (cmd == CMD_RD ##[1:4] cmd == CMD_RD);
  cover property (cmd == CMD_WR ##[1:8] cmd == CMD_RD);
endmodule // ddb_link_properties
